// >>> pcr_pkg.sv
// package: register map, field layout, reset values and shared types of the pwm reload/sync block
`default_nettype none
package pcr_pkg;
  localparam logic [7:0] PCR_OFS_CYCLE   = 8'h00;
  localparam logic [7:0] PCR_OFS_TRIG    = 8'h04;
  localparam logic [7:0] PCR_OFS_PH2     = 8'h08;
  localparam logic [7:0] PCR_OFS_PH3     = 8'h0C;
  localparam logic [7:0] PCR_OFS_CULL    = 8'h10;
  localparam logic [7:0] PCR_OFS_SCMP0   = 8'h14;
  localparam logic [7:0] PCR_OFS_SCMP1   = 8'h18;
  localparam logic [7:0] PCR_OFS_MCTL0   = 8'h1C;
  localparam logic [7:0] PCR_OFS_MCTL1   = 8'h20;
  localparam logic [7:0] PCR_OFS_MOPT0   = 8'h24;
  localparam logic [7:0] PCR_OFS_SCTL0   = 8'h28;
  localparam logic [7:0] PCR_OFS_SCTL1   = 8'h2C;
  localparam logic [7:0] PCR_OFS_OUTCTL  = 8'h30;
  localparam logic [7:0] PCR_OFS_OPT2    = 8'h34;
  localparam logic [7:0] PCR_OFS_STATUS  = 8'h38;
  localparam logic [7:0] PCR_OFS_BCYCLE  = 8'h3C;
  localparam logic [7:0] PCR_OFS_BTRIG   = 8'h40;
  localparam logic [7:0] PCR_OFS_BPH2    = 8'h44;
  localparam logic [7:0] PCR_OFS_BPH3    = 8'h48;
  localparam logic [7:0] PCR_OFS_BCULL   = 8'h4C;
  localparam logic [7:0] PCR_OFS_BSCMP0  = 8'h50;
  localparam logic [7:0] PCR_OFS_BSCMP1  = 8'h54;
  localparam logic [7:0] PCR_OFS_MCNT    = 8'h58;
  localparam logic [7:0] PCR_OFS_SCNT    = 8'h5C;
  // field positions
  localparam int PCR_CE_BIT        = 7;  // count enable in control 0
  localparam int PCR_CMS_BIT       = 0;  // rewrite_mode_select in master option 0
  localparam int PCR_RDE_BIT       = 7;  // culled_transfer_enable in trigger select a
  localparam int PCR_SYE_BIT       = 7;  // slave_sync_enable in slave control 1
  localparam int PCR_ICE_BIT       = 7;  // crest_interrupt_enable in culling option
  localparam int PCR_IOE_BIT       = 6;  // valley_interrupt_enable in culling option
  localparam int PCR_OE0_BIT       = 0;  // positive_phase_output_enable
  localparam int PCR_OL0_BIT       = 1;  // positive_phase_level
  localparam int PCR_PRS_LSB       = 0;  // prescale select in control 0
  localparam int PCR_PRS_W         = 3;
  localparam int PCR_RATIO_W       = 5;  // culling_ratio_field
  // reset values
  localparam logic [15:0] PCR_CYCLE_RST = 16'hFFFF;
  localparam logic [15:0] PCR_CMP_RST   = 16'h0000;
  localparam logic [7:0]  PCR_BYTE_RST  = 8'h00;
  localparam logic [15:0] PCR_VALLEY_CNT = 16'h0001;
  localparam logic [15:0] PCR_SLAVE_START = 16'h0000;

  typedef struct packed {
    logic [15:0] cycle;
    logic [15:0] trig;
    logic [15:0] ph2;
    logic [15:0] ph3;
    logic [7:0]  cull;
    logic [15:0] scmp0;
    logic [15:0] scmp1;
  } pcr_bank_type;

  typedef struct packed {
    logic crest;
    logic valley;
    logic crest_kept;
    logic valley_kept;
    logic down;
  } pcr_evt_type;
endpackage
`default_nettype wire

// >>> pcr_cull.sv
// culling counter that thins crest and valley events into kept events
`default_nettype none
module pcr_cull
  import pcr_pkg::*;
#(
  parameter int RATIO_W = PCR_RATIO_W
) (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic               crest,
  input  wire logic               valley,
  input  wire logic               crest_en,
  input  wire logic               valley_en,
  input  wire logic [RATIO_W-1:0] ratio,
  output logic                    crest_kept,
  output logic                    valley_kept
);
  if (RATIO_W < 1 || RATIO_W > 8) begin : g_bad_ratio
    $error("pcr_cull: RATIO_W out of range");
  end

  typedef struct packed {
    logic [RATIO_W-1:0] cnt;
  } pcr_cull_st_type;

  pcr_cull_st_type st_q, st_d;
  logic            hit;
  logic            pass;

  // counting enabled events only; a ratio of n keeps one of every n+1
  assign hit  = (crest && crest_en) || (valley && valley_en);
  assign pass = hit && (st_q.cnt == ratio);
  assign crest_kept  = pass && crest && crest_en;
  assign valley_kept = pass && valley && valley_en;

  always_comb begin
    st_d = st_q;
    if (hit) begin
      st_d.cnt = pass ? '0 : st_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule
`default_nettype wire

// >>> pcr_prescale.sv
// count tick generator from the master's operating clock selection, or the slave's while only the uncoupled slave runs
`default_nettype none
module pcr_prescale
  import pcr_pkg::*;
#(
  parameter int SEL_W = PCR_PRS_W
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             run,
  input  wire logic [SEL_W-1:0] sel,
  output logic                  tick
);
  if (SEL_W < 1 || SEL_W > 4) begin : g_bad_sel
    $error("pcr_prescale: SEL_W out of range");
  end

  typedef struct packed {
    logic [15:0] div;
  } pcr_prs_st_type;

  pcr_prs_st_type st_q, st_d;
  logic [15:0]    mask;

  // divide by 2**sel; one tick feeds both counters so they move on the same edge
  assign mask = 16'((32'h1 << sel) - 1);
  assign tick = run && ((st_q.div & mask) == 16'h0000);

  always_comb begin
    st_d = st_q;
    st_d.div = run ? st_q.div + 16'h0001 : 16'h0000;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule
`default_nettype wire

// >>> pcr_top.sv
// three-phase pwm master/slave timer core: batch reload of compares and slave coupling, apb registers
//
// Our own choices: register access over APB and the register addresses.
`default_nettype none
module pcr_top
  import pcr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  output logic [2:0]       pwm_pos,
  output logic             crest_interrupt,
  output logic             valley_interrupt,
  output logic             slave_match_interrupt_0,
  output logic             slave_match_interrupt_1
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    pcr_bank_type wr;      // software-visible buffered registers
    pcr_bank_type buf_;    // internal compare buffers
    logic         req;     // transfer request flag
    logic [7:0]   mctl0;
    logic [7:0]   mctl1;
    logic [7:0]   mopt0;
    logic [7:0]   sctl0;
    logic [7:0]   sctl1;
    logic [7:0]   outctl;
    logic [7:0]   opt2;
    logic [15:0]  mcnt;
    logic         down;
    logic [15:0]  scnt;
    logic [2:0]   pwm;
    logic         scc0;
    logic         scc1;
    logic [31:0]  rdata;
  } pcr_st_type;

  pcr_st_type st_q, st_d;

  logic        wr_en;
  logic        rd_en;
  logic        mapped;
  logic        m_run;
  logic        s_run;
  logic        coupled;
  logic        batch;
  logic        culled;
  logic        tick;
  logic        pos_ok;
  logic        crest_raw;
  logic        valley_raw;
  logic        crest_kept;
  logic        valley_kept;
  logic        xfer_evt;
  logic [15:0] wval;

  ////////////////////////////////////////////////////////////////////////////
  // apb: zero wait states, unmapped addresses answer with pslverr
  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !penable && !pwrite;
  assign wval    = pwdata[15:0];
  assign prdata  = st_q.rdata;
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    unique case (paddr)
      PCR_OFS_CYCLE, PCR_OFS_TRIG, PCR_OFS_PH2, PCR_OFS_PH3, PCR_OFS_CULL,
      PCR_OFS_SCMP0, PCR_OFS_SCMP1, PCR_OFS_MCTL0, PCR_OFS_MCTL1, PCR_OFS_MOPT0,
      PCR_OFS_SCTL0, PCR_OFS_SCTL1, PCR_OFS_OUTCTL, PCR_OFS_OPT2, PCR_OFS_STATUS,
      PCR_OFS_BCYCLE, PCR_OFS_BTRIG, PCR_OFS_BPH2, PCR_OFS_BPH3, PCR_OFS_BCULL,
      PCR_OFS_BSCMP0, PCR_OFS_BSCMP1, PCR_OFS_MCNT, PCR_OFS_SCNT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode decode
  assign m_run   = st_q.mctl0[PCR_CE_BIT];
  assign coupled = st_q.sctl1[PCR_SYE_BIT];
  assign s_run   = st_q.sctl0[PCR_CE_BIT];
  assign batch   = !st_q.mopt0[PCR_CMS_BIT];
  assign culled  = batch && st_q.opt2[PCR_RDE_BIT];
  // crest and valley detection rides on the positive phase output path
  assign pos_ok  = st_q.outctl[PCR_OE0_BIT] && !st_q.outctl[PCR_OL0_BIT];

  // the counter passes both values on the way up and down; only the turning points count
  assign crest_raw  = m_run && pos_ok && tick && !st_q.down && (st_q.mcnt == st_q.buf_.cycle);
  assign valley_raw = m_run && pos_ok && tick && st_q.down && (st_q.mcnt == PCR_VALLEY_CNT);

  // slave runs on the master's selection while coupled; its own selection is ignored
  pcr_prescale #(
    .SEL_W (PCR_PRS_W)
  ) u_prs (
    .clk  (clk),
    .nrst (nrst),
    .run  (m_run || (s_run && !coupled)),
    .sel  (coupled ? st_q.mctl0[PCR_PRS_LSB +: PCR_PRS_W]
                   : (m_run ? st_q.mctl0[PCR_PRS_LSB +: PCR_PRS_W]
                            : st_q.sctl0[PCR_PRS_LSB +: PCR_PRS_W])),
    .tick (tick)
  );

  pcr_cull #(
    .RATIO_W (PCR_RATIO_W)
  ) u_cull (
    .clk         (clk),
    .nrst        (nrst),
    .crest       (crest_raw),
    .valley      (valley_raw),
    .crest_en    (st_q.buf_.cull[PCR_ICE_BIT]),
    .valley_en   (st_q.buf_.cull[PCR_IOE_BIT]),
    .ratio       (st_q.buf_.cull[PCR_RATIO_W-1:0]),
    .crest_kept  (crest_kept),
    .valley_kept (valley_kept)
  );

  // plain batch mode uses every crest and valley; culled mode only the kept ones
  assign xfer_evt = culled ? (crest_kept || valley_kept) : (crest_raw || valley_raw);

  assign crest_interrupt         = crest_kept;
  assign valley_interrupt        = valley_kept;
  assign slave_match_interrupt_0 = st_q.scc0;
  assign slave_match_interrupt_1 = st_q.scc1;
  assign pwm_pos                 = st_q.pwm;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    st_d.scc0 = 1'b0;
    st_d.scc1 = 1'b0;

    // register writes
    if (wr_en) begin
      unique case (paddr)
        PCR_OFS_CYCLE:  st_d.wr.cycle = wval;
        PCR_OFS_TRIG:   st_d.wr.trig  = wval;
        PCR_OFS_PH2:    st_d.wr.ph2   = wval;
        PCR_OFS_PH3:    st_d.wr.ph3   = wval;
        PCR_OFS_CULL:   st_d.wr.cull  = pwdata[7:0];
        PCR_OFS_SCMP0:  st_d.wr.scmp0 = wval;
        PCR_OFS_SCMP1:  st_d.wr.scmp1 = wval;
        PCR_OFS_MCTL0:  st_d.mctl0    = pwdata[7:0];
        PCR_OFS_MCTL1:  st_d.mctl1    = pwdata[7:0];
        PCR_OFS_MOPT0:  st_d.mopt0    = pwdata[7:0];
        PCR_OFS_SCTL0:  st_d.sctl0    = pwdata[7:0];
        PCR_OFS_SCTL1:  st_d.sctl1    = pwdata[7:0];
        PCR_OFS_OUTCTL: st_d.outctl   = pwdata[7:0];
        PCR_OFS_OPT2:   st_d.opt2     = pwdata[7:0];
        default: ;
      endcase
    end

    // anytime mode: buffers follow writes at once; an independent slave always does
    if (!batch) begin
      st_d.buf_ = st_d.wr;
    end else if (!coupled) begin
      st_d.buf_.scmp0 = st_d.wr.scmp0;
      st_d.buf_.scmp1 = st_d.wr.scmp1;
    end

    // batch request and transfer; a new trigger write in the transfer cycle stays pending
    if (batch && st_q.req && xfer_evt) begin
      st_d.buf_ = st_q.wr;
      if (!coupled) begin
        st_d.buf_.scmp0 = st_d.wr.scmp0;
        st_d.buf_.scmp1 = st_d.wr.scmp1;
      end
      st_d.req = 1'b0;
    end
    // otherwise the flag and buffers just wait
    if (wr_en && paddr == PCR_OFS_TRIG && batch) begin
      st_d.req = 1'b1;
    end
    if (st_d.mopt0[PCR_CMS_BIT]) begin
      st_d.req = 1'b0;
    end

    // master up/down counter: 0 .. cycle up, cycle+1 .. 1 down
    if (!m_run) begin
      st_d.mcnt = PCR_SLAVE_START;
      st_d.down = 1'b0;
    end else if (tick) begin
      if (!st_q.down) begin
        if (st_q.mcnt == st_q.buf_.cycle) begin
          st_d.down = 1'b1;
          st_d.mcnt = st_q.mcnt + 16'h0001;
        end else begin
          st_d.mcnt = st_q.mcnt + 16'h0001;
        end
      end else begin
        if (st_q.mcnt == PCR_VALLEY_CNT) begin
          st_d.down = 1'b0;
          st_d.mcnt = PCR_SLAVE_START;
        end else begin
          st_d.mcnt = st_q.mcnt - 16'h0001;
        end
      end
    end

    // slave counter: up only, cleared at the cycle value while coupled, both directions of master
    if (!s_run) begin
      st_d.scnt = PCR_SLAVE_START;
    end else if (tick && (m_run || !coupled)) begin
      if (coupled && st_q.scnt == st_q.buf_.cycle) begin
        st_d.scnt = PCR_SLAVE_START;
      end else begin
        st_d.scnt = st_q.scnt + 16'h0001;
      end
      st_d.scc0 = (st_q.scnt == st_q.buf_.scmp0);
      st_d.scc1 = (st_q.scnt == st_q.buf_.scmp1);
    end

    // triangular compare outputs: high while counter is below the phase value; output 0 only while the positive phase output is on
    st_d.pwm[0] = m_run && pos_ok && (st_q.mcnt < st_q.buf_.trig);
    st_d.pwm[1] = m_run && (st_q.mcnt < st_q.buf_.ph2);
    st_d.pwm[2] = m_run && (st_q.mcnt < st_q.buf_.ph3);

    // read data captured in setup so it stands through the access phase
    if (rd_en) begin
      unique case (paddr)
        PCR_OFS_CYCLE:  st_d.rdata = {16'h0000, st_q.wr.cycle};
        PCR_OFS_TRIG:   st_d.rdata = {16'h0000, st_q.wr.trig};
        PCR_OFS_PH2:    st_d.rdata = {16'h0000, st_q.wr.ph2};
        PCR_OFS_PH3:    st_d.rdata = {16'h0000, st_q.wr.ph3};
        PCR_OFS_CULL:   st_d.rdata = {24'h000000, st_q.wr.cull};
        PCR_OFS_SCMP0:  st_d.rdata = {16'h0000, st_q.wr.scmp0};
        PCR_OFS_SCMP1:  st_d.rdata = {16'h0000, st_q.wr.scmp1};
        PCR_OFS_MCTL0:  st_d.rdata = {24'h000000, st_q.mctl0};
        PCR_OFS_MCTL1:  st_d.rdata = {24'h000000, st_q.mctl1};
        PCR_OFS_MOPT0:  st_d.rdata = {24'h000000, st_q.mopt0};
        PCR_OFS_SCTL0:  st_d.rdata = {24'h000000, st_q.sctl0};
        PCR_OFS_SCTL1:  st_d.rdata = {24'h000000, st_q.sctl1};
        PCR_OFS_OUTCTL: st_d.rdata = {24'h000000, st_q.outctl};
        PCR_OFS_OPT2:   st_d.rdata = {24'h000000, st_q.opt2};
        PCR_OFS_STATUS: st_d.rdata = {28'h0000000, culled, coupled, st_q.down, st_q.req};
        PCR_OFS_BCYCLE: st_d.rdata = {16'h0000, st_q.buf_.cycle};
        PCR_OFS_BTRIG:  st_d.rdata = {16'h0000, st_q.buf_.trig};
        PCR_OFS_BPH2:   st_d.rdata = {16'h0000, st_q.buf_.ph2};
        PCR_OFS_BPH3:   st_d.rdata = {16'h0000, st_q.buf_.ph3};
        PCR_OFS_BCULL:  st_d.rdata = {24'h000000, st_q.buf_.cull};
        PCR_OFS_BSCMP0: st_d.rdata = {16'h0000, st_q.buf_.scmp0};
        PCR_OFS_BSCMP1: st_d.rdata = {16'h0000, st_q.buf_.scmp1};
        PCR_OFS_MCNT:   st_d.rdata = {16'h0000, st_q.mcnt};
        PCR_OFS_SCNT:   st_d.rdata = {16'h0000, st_q.scnt};
        default:        st_d.rdata = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q            <= '0;
      st_q.wr.cycle   <= PCR_CYCLE_RST;
      st_q.buf_.cycle <= PCR_CYCLE_RST;
      st_q.mopt0      <= PCR_BYTE_RST;
    end else begin
      st_q <= st_d;
    end
  end
endmodule
`default_nettype wire

// >>> pcr_top_properties.sv
// checker: apb answers, read data holding and event gating seen at the top ports
`default_nettype none
module pcr_props
  import pcr_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        crest_interrupt,
  input wire logic        valley_interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  // shadow of the output control bits, updated on the same edge as the design
  logic oe_q;
  logic ol_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      oe_q <= 1'b0;
      ol_q <= 1'b0;
    end else if (psel && penable && pwrite && paddr == PCR_OFS_OUTCTL) begin
      oe_q <= pwdata[PCR_OE0_BIT];
      ol_q <= pwdata[PCR_OL0_BIT];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_access: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
  a_err_mapped: assert property (psel && penable && paddr <= 8'h5C && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("pslverr on mapped address");
  a_err_unmapped: assert property (psel && penable && paddr > 8'h5C |-> pslverr) else $error("no pslverr");
  a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata)) else $error("prdata moved");
  a_rdata_upper: assert property (psel && !penable && !pwrite |=> prdata[31:16] == 16'h0000)
    else $error("prdata upper bits set");
  a_rdata_unmapped: assert property (psel && !penable && !pwrite && paddr > 8'h5C |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_events_apart: assert property (!(crest_interrupt && valley_interrupt)) else $error("crest and valley together");
  a_evt_needs_out: assert property (crest_interrupt || valley_interrupt |-> oe_q && !ol_q)
    else $error("event without positive phase output");
  cover property (psel && penable && pwrite && paddr == PCR_OFS_TRIG);
endmodule
bind pcr_top pcr_props chk_u (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .crest_interrupt(crest_interrupt), .valley_interrupt(valley_interrupt));
`default_nettype wire

// >>> pcr_top_tb.sv
// testbench: apb scenarios for batch reload, culled transfer and slave coupling
`default_nettype none
module pcr_top_tb
  import pcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] M = 32'h0020;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic [2:0]  pwm_pos;
  logic [3:0]  evt;
  int          mismatches = 0;
  int          cmp_count = 0;
  pcr_top dut_u (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .pwm_pos(pwm_pos),
    .crest_interrupt(evt[0]), .valley_interrupt(evt[1]), .slave_match_interrupt_0(evt[2]),
    .slave_match_interrupt_1(evt[3]));
  always #2 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one setup cycle, then access until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    rd(a, r);
    chk(r, exp);
  endtask
  // waits for event k (0 crest, 1 valley, 2/3 slave matches); n counts edges
  task automatic wait_evt(input int k, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (evt[k] !== 1'b1 && n < 2000);
    chk(n < 2000, 1'b1);
  endtask
  // polls the request flag until the transfer has happened; down shows where
  task automatic xfer(input logic use_dn, input logic exp_dn);
    logic [31:0] s;
    int n;
    n = 0;
    do begin
      rd(PCR_OFS_STATUS, s);
      n++;
    end while (s[0] !== 1'b0 && n < 300);
    chk(s[0], 1'b0);
    if (use_dn) chk(s[1], exp_dn);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic s_reset();
    logic [31:0] r;
    logic e;
    rdc(PCR_OFS_CYCLE, 32'h0000FFFF);
    rdc(PCR_OFS_BCYCLE, 32'h0000FFFF);
    rdc(PCR_OFS_STATUS, 32'h0);
    apb(1'b1, 8'h60, 32'hFFFF, r, e);
    chk(e, 1'b1);
    apb(1'b0, 8'h60, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    wr(PCR_OFS_BPH2, 32'h1234);
    rdc(PCR_OFS_BPH2, 32'h0);
  endtask
  task automatic s_cancel();
    wr(PCR_OFS_PH3, 32'h0033);
    wr(PCR_OFS_TRIG, 32'h0005);
    rdc(PCR_OFS_STATUS, 32'h1);
    repeat (40) @(posedge clk);
    rdc(PCR_OFS_BPH3, 32'h0);
    rdc(PCR_OFS_STATUS, 32'h1);
    wr(PCR_OFS_MOPT0, 32'h1);
    rdc(PCR_OFS_STATUS, 32'h0);
    wr(PCR_OFS_PH2, 32'h0111);
    rdc(PCR_OFS_BPH2, 32'h0111);
  endtask
  // coupling; the slave's own slow prescale must be ignored
  task automatic s_start();
    logic [31:0] r;
    logic [31:0] last;
    int drops;
    int n;
    drops = 0;
    last = 0;
    wr(PCR_OFS_CYCLE, M);
    wr(PCR_OFS_CULL, 32'hC0);
    wr(PCR_OFS_SCTL1, 32'h85);
    wr(PCR_OFS_SCMP0, 32'h0008);
    wr(PCR_OFS_SCMP1, 32'h0018);
    wr(PCR_OFS_MCTL1, 32'h07);
    wr(PCR_OFS_OUTCTL, 32'h01);
    wr(PCR_OFS_SCTL0, 32'h87);
    wr(PCR_OFS_MCTL0, 32'h80);
    wr(PCR_OFS_MOPT0, 32'h0);
    wr(PCR_OFS_OPT2, 32'h80);
    rd(PCR_OFS_STATUS, r);
    chk(r & 32'hC, 32'hC);
    for (int i = 0; i < 40; i++) begin
      rd(PCR_OFS_SCNT, r);
      chk(r <= M, 1'b1);
      if (r < last) drops++;
      last = r;
    end
    chk(drops >= 1, 1'b1);
    wait_evt(2, n);
    wait_evt(3, n);
  endtask
  task automatic s_batch();
    int n;
    wr(PCR_OFS_CULL, 32'h80);
    wr(PCR_OFS_PH2, 32'h000A);
    wr(PCR_OFS_SCMP0, 32'h000C);
    rdc(PCR_OFS_BPH2, 32'h0111);
    wr(PCR_OFS_TRIG, 32'h0);
    xfer(1'b0, 1'b0);
    rdc(PCR_OFS_BPH2, 32'h000A);
    rdc(PCR_OFS_BSCMP0, 32'h000C);
    rdc(PCR_OFS_BCULL, 32'h80);
    rdc(PCR_OFS_BCYCLE, M);
    wr(PCR_OFS_PH3, 32'h000B);
    wr(PCR_OFS_CULL, 32'h40);
    wr(PCR_OFS_TRIG, 32'h0003);
    xfer(1'b1, 1'b1);
    rdc(PCR_OFS_BPH3, 32'h000B);
    wr(PCR_OFS_PH2, 32'h0007);
    wr(PCR_OFS_TRIG, 32'h0003);
    xfer(1'b1, 1'b0);
    rdc(PCR_OFS_BPH2, 32'h0007);
    rdc(PCR_OFS_BTRIG, 32'h0003);
    // five ticks past the valley the count sits between trigger 3 and phase2 7
    wait_evt(1, n);
    repeat (6) @(posedge clk);
    chk(pwm_pos, 3'b110);
  endtask
  // culling ratio one keeps every second valley, only once transferred
  task automatic s_cull();
    int g1;
    int g;
    int n;
    wait_evt(1, n);
    wait_evt(1, g1);
    wr(PCR_OFS_CULL, 32'h41);
    wait_evt(1, n);
    wait_evt(1, g);
    chk(g, g1);
    wr(PCR_OFS_TRIG, 32'h0003);
    xfer(1'b0, 1'b0);
    wait_evt(1, n);
    wait_evt(1, g);
    chk(g, 2 * g1);
    wr(PCR_OFS_OUTCTL, 32'h03);
    n = 0;
    repeat (300) begin
      @(posedge clk);
      if (evt[1:0] !== 2'b00) n++;
    end
    chk(n, 0);
  endtask
  // shutdown, then the lone slave's compares bypass the batch settings
  task automatic s_stop();
    logic [31:0] r;
    wr(PCR_OFS_MCTL0, 32'h0);
    wr(PCR_OFS_SCTL0, 32'h0);
    wr(PCR_OFS_OUTCTL, 32'h0);
    wr(PCR_OFS_SCTL1, 32'h0);
    rd(PCR_OFS_STATUS, r);
    chk(r[2], 1'b0);
    chk(pwm_pos, 3'b000);
    wr(PCR_OFS_SCMP1, 32'h0055);
    rdc(PCR_OFS_BSCMP1, 32'h0055);
    wr(PCR_OFS_PH2, 32'h0066);
    rdc(PCR_OFS_BPH2, 32'h0007);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #80000;
    mismatches++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    s_reset();
    s_cancel();
    s_start();
    s_batch();
    s_cull();
    s_stop();
    stop_test();
  end
endmodule
`default_nettype wire
